// *** hdl/nvm_prot.sv ***
// Protection control of the flash/EEPROM controller: divider, EEPROM
// protection, protection override command, AXI4-Lite registers.
// Assumes configuration values are stable from reset release and the
// EEPROM operation request comes from logic on clk.
//
// Overview of operation
// R1: Divider bit 7 read-only; bit 6 write-once locks field; special mode free.
// R2: Protection-open bit set disables EEPROM protection, size field ignored.
// R3: Special single chip mode writes open bit and size without limits.
// R4: Reset loads open bit and size from stored configuration protection byte.
// R5: Double-bit fault on that read leaves EEPROM fully protected.
// R6: Program or erase inside protected range is rejected, violation flag set.
// R7: EEPROM block erase refused while any sector is protected.
// R8: Protection register: open control bit 7, size field bits 6 to 0.
// R9: Range starts at EEPROM base, size is (field plus one) times 32 bytes.
// R10: Override command code 0x13; words carry selection, key, new values.
// R11: Selection bit 0 updates flash protection, bit 1 EEPROM protection.
// R12: An all-ones key is invalid and disables the override.
// R13: A valid key not matching the stored key disables the override.
// R14: On match save current values, write selected ones, set override bit.
// R15: On mismatch restore saved values and clear the override bit.
// R16: Erased stored key keeps the override permanently disabled.
// R17: Command with access error leaves both protection registers unchanged.
// R18: Command completion reported on the command-complete flag after update.
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
module nvm_prot
    import nvm_prot_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter int SIZE_W = 7
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic ce,
    input wire logic special_mode_pin,
    input wire logic [7:0] cfg_eeprom_prot_byte,
    input wire logic cfg_double_fault,
    input wire logic [7:0] cfg_flash_prot_byte,
    input wire logic [15:0] cfg_override_key,
    input wire logic op_req,
    input wire logic [23:0] op_addr,
    input wire logic op_block_erase,
    output logic op_reject,
    output logic op_accept,
    output logic irq,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    typedef enum logic {C_IDLE, C_EXEC} cmd_state_t;

    logic spec_m_q, spec_q;
    logic load_q;
    logic [7:0] div_q, fl_prot_q, eprot_q, fsave_q, esave_q;
    logic [15:0] key_q;
    logic ovrd_q, done_q, acc_err_q, viol_q;
    logic [2:0] ien_q, ist_q;
    logic [7:0] cmd_q [CMD_BYTES];
    cmd_state_t state_q;
    logic aw_full_q, w_full_q;
    logic [5:0] aw_idx_q;
    logic aw_ok_q;
    logic [7:0] wdata_q;
    logic wstrb0_q;

    // ----------------------------------------
    // Strap synchroniser
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            spec_m_q <= 1'b0;
            spec_q <= 1'b0;
        end else if (ce) begin
            spec_m_q <= special_mode_pin;
            spec_q <= spec_m_q;
        end
    end

    // ----------------------------------------
    // Bus write decode
    // ----------------------------------------
    logic wr_en;
    logic [7:0] wb;
    assign wr_en = ce && aw_full_q && w_full_q && !s_axi_bvalid
        && wstrb0_q && aw_ok_q;
    assign wb = wdata_q;

    function automatic logic is_mapped(input logic [5:0] idx);
        return idx <= IDX_IRQ_CLEAR
            || (idx >= IDX_CMD_FIRST && idx <= IDX_CMD_LAST);
    endfunction

    logic wr_div, wr_status, wr_fl_prot, wr_eprot, wr_ien, wr_iclr;
    assign wr_div = wr_en && aw_idx_q == IDX_DIVIDER;
    assign wr_status = wr_en && aw_idx_q == IDX_STATUS;
    assign wr_fl_prot = wr_en && aw_idx_q == IDX_FL_PROT;
    assign wr_eprot = wr_en && aw_idx_q == IDX_EPROT;
    assign wr_ien = wr_en && aw_idx_q == IDX_IRQ_ENABLE;
    assign wr_iclr = wr_en && aw_idx_q == IDX_IRQ_CLEAR;

    // ----------------------------------------
    // Timing divider
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            div_q <= DIV_RESET;
        end else if (ce && wr_div) begin
            // Bit 7 only reports that a value was written; see R1
            div_q[DIV_LOADED_BIT] <= 1'b1;
            if (spec_q) begin
                div_q[6:0] <= wb[6:0]; // see R1
            end else if (!div_q[DIV_LOCK_BIT]) begin
                div_q[6:0] <= wb[6:0]; // see R1
            end
        end
    end

    // ----------------------------------------
    // Override command
    // ----------------------------------------
    logic [15:0] cmd_key;
    logic code_ok, key_bad, key_match, launch;
    logic [1:0] sel;
    assign cmd_key = {cmd_q[2], cmd_q[3]};
    assign sel = cmd_q[1][1:0];
    assign code_ok = cmd_q[0] == CMD_OVERRIDE; // see R10
    // An erased stored key can never match; see R16
    assign key_bad = cmd_key == KEY_ERASED || key_q == KEY_ERASED; // see R12
    assign key_match = !key_bad && cmd_key == key_q; // see R13
    assign launch = wr_status && wb[STATUS_DONE_BIT] && done_q && !load_q;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_q <= C_IDLE;
            done_q <= 1'b1;
        end else if (ce) begin
            case (state_q)
                C_IDLE: begin
                    if (launch) begin
                        state_q <= C_EXEC;
                        done_q <= 1'b0;
                    end
                end
                C_EXEC: begin
                    state_q <= C_IDLE;
                    done_q <= 1'b1; // see R18
                end
                default: begin
                    state_q <= C_IDLE;
                    done_q <= 1'b1;
                end
            endcase
        end
    end

    logic exec, ex_err, ex_hit, ex_miss;
    assign exec = ce && state_q == C_EXEC;
    assign ex_err = exec && !code_ok; // see R17
    assign ex_hit = exec && code_ok && key_match;
    assign ex_miss = exec && code_ok && !key_match;

    // Parameter words only change while no command runs
    genvar gi;
    generate
        for (gi = 0; gi < CMD_BYTES; gi++) begin : g_cmd
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    cmd_q[gi] <= 8'h00;
                end else if (wr_en && done_q
                        && aw_idx_q == IDX_CMD_FIRST + 6'(gi)) begin
                    cmd_q[gi] <= wb;
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // Protection registers
    // ----------------------------------------
    logic [SIZE_W-1:0] e_size, w_size;
    assign e_size = eprot_q[SIZE_W-1:0]; // see R8
    assign w_size = wb[SIZE_W-1:0];

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            load_q <= 1'b1;
            eprot_q <= EPROT_FULL;
            fl_prot_q <= FL_PROT_RESET;
            esave_q <= EPROT_FULL;
            fsave_q <= FL_PROT_RESET;
            key_q <= KEY_ERASED;
            ovrd_q <= 1'b0;
        end else if (ce) begin
            if (load_q) begin
                load_q <= 1'b0;
                // Fault read keeps the whole EEPROM protected; see R5
                eprot_q <= cfg_double_fault ? EPROT_FULL
                    : cfg_eeprom_prot_byte; // see R4
                fl_prot_q <= cfg_flash_prot_byte;
                key_q <= cfg_override_key;
            end else if (ex_hit) begin
                // Save only once so a later miss restores the originals
                if (!ovrd_q) begin
                    fsave_q <= fl_prot_q; // see R14
                    esave_q <= eprot_q;
                end
                if (sel[0]) begin
                    fl_prot_q <= cmd_q[5]; // see R11
                end
                if (sel[1]) begin
                    eprot_q <= cmd_q[7]; // see R11
                end
                ovrd_q <= 1'b1; // see R14
            end else if (ex_miss) begin
                if (ovrd_q) begin
                    fl_prot_q <= fsave_q; // see R15
                    eprot_q <= esave_q;
                end
                ovrd_q <= 1'b0; // see R15
            end else if (wr_eprot && spec_q) begin
                eprot_q <= wb; // see R3
            end else if (wr_eprot && !ovrd_q) begin
                // Normal mode may only tighten protection
                eprot_q[EPROT_OPEN_BIT] <= eprot_q[EPROT_OPEN_BIT]
                    & wb[EPROT_OPEN_BIT];
                if (w_size > e_size) begin
                    eprot_q[SIZE_W-1:0] <= w_size;
                end
            end else if (wr_fl_prot && spec_q) begin
                fl_prot_q <= wb;
            end
        end
    end

    // ----------------------------------------
    // EEPROM access check
    // ----------------------------------------
    logic [23:0] range_end;
    logic in_range, rej;
    // see R9
    assign range_end = EEPROM_BASE
        + ({17'h0, e_size} + 24'h1 << SECTOR_SHIFT) - 24'h1;
    assign in_range = op_addr >= EEPROM_BASE && op_addr <= range_end;
    // Open bit overrides the size field; see R2
    assign rej = !eprot_q[EPROT_OPEN_BIT] && (op_block_erase || in_range);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            op_reject <= 1'b0;
            op_accept <= 1'b0;
        end else if (ce) begin
            op_reject <= op_req && !load_q && rej; // see R6 R7
            op_accept <= op_req && !load_q && !rej;
        end
    end

    // ----------------------------------------
    // Status flags and interrupt
    // ----------------------------------------
    logic viol_set, done_set;
    assign viol_set = ce && op_req && !load_q && rej;
    assign done_set = exec;

    // Set wins over a clear in the same cycle
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            acc_err_q <= 1'b0;
            viol_q <= 1'b0;
        end else if (ce) begin
            acc_err_q <= ex_err
                || (acc_err_q && !(wr_status && wb[STATUS_ERR_BIT]));
            viol_q <= viol_set // see R6
                || (viol_q && !(wr_status && wb[STATUS_VIOL_BIT]));
        end
    end

    logic [2:0] iev, iclr;
    assign iev = {ex_err, viol_set, done_set};
    assign iclr = wr_iclr ? wb[2:0] : 3'h0;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ist_q <= 3'h0;
            ien_q <= 3'h0;
        end else if (ce) begin
            ist_q <= (ist_q & ~iclr) | iev;
            if (wr_ien) begin
                ien_q <= wb[2:0];
            end
        end
    end
    assign irq = |(ist_q & ien_q);

    // ----------------------------------------
    // AXI4-Lite slave
    // ----------------------------------------
    assign s_axi_awready = !aw_full_q && !s_axi_bvalid;
    assign s_axi_wready = !w_full_q && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            aw_idx_q <= 6'h00;
            aw_ok_q <= 1'b0;
            wdata_q <= 8'h00;
            wstrb0_q <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full_q <= 1'b1;
                aw_idx_q <= s_axi_awaddr[7:2];
                aw_ok_q <= is_mapped(s_axi_awaddr[7:2]);
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full_q <= 1'b1;
                wdata_q <= s_axi_wdata[7:0];
                wstrb0_q <= s_axi_wstrb[0];
            end
            if (aw_full_q && w_full_q && !s_axi_bvalid) begin
                aw_full_q <= 1'b0;
                w_full_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= aw_ok_q ? RESP_OKAY : RESP_DECERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    function automatic logic [7:0] rd_mux(input logic [5:0] idx);
        logic [7:0] v;
        v = 8'h00;
        case (idx)
            IDX_DIVIDER: v = div_q;
            IDX_STATUS: v = {done_q, 1'b0, acc_err_q, viol_q, 4'h0};
            IDX_PSTAT: v = {7'h0, ovrd_q};
            IDX_FL_PROT: v = fl_prot_q;
            IDX_EPROT: v = eprot_q;
            IDX_IRQ_STATUS: v = {5'h0, ist_q};
            IDX_IRQ_ENABLE: v = {5'h0, ien_q};
            default: begin
                if (idx >= IDX_CMD_FIRST && idx <= IDX_CMD_LAST) begin
                    v = cmd_q[4'(idx - IDX_CMD_FIRST)];
                end
            end
        endcase
        return v;
    endfunction

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_OKAY;
        end else if (ce) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= {24'h0, rd_mux(s_axi_araddr[7:2])};
                s_axi_rresp <= is_mapped(s_axi_araddr[7:2]) ? RESP_OKAY
                    : RESP_DECERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    property p_div_lock;
        @(posedge clk) disable iff (sys_rst)
        div_q[DIV_LOCK_BIT] && !spec_q |=> div_q[6:0] == $past(div_q[6:0]);
    endproperty
    a_div_lock: assert property (p_div_lock) // see R1
        else $error("divider changed while locked");

    property p_open_pass;
        @(posedge clk) disable iff (sys_rst)
        ce && op_req && !load_q && eprot_q[EPROT_OPEN_BIT] |=> !op_reject;
    endproperty
    a_open_pass: assert property (p_open_pass) // see R2
        else $error("rejected with protection open");

    property p_fault_load;
        @(posedge clk) disable iff (sys_rst)
        ce && load_q && cfg_double_fault |=> eprot_q == EPROT_FULL;
    endproperty
    a_fault_load: assert property (p_fault_load) // see R5
        else $error("fault load not fully protected");

    property p_viol;
        @(posedge clk) disable iff (sys_rst)
        ce && op_req && !load_q && !eprot_q[EPROT_OPEN_BIT] && in_range
            |=> op_reject && viol_q;
    endproperty
    a_viol: assert property (p_viol) // see R6
        else $error("protected access not rejected");

    property p_blk_erase;
        @(posedge clk) disable iff (sys_rst)
        ce && op_req && !load_q && op_block_erase
            && !eprot_q[EPROT_OPEN_BIT] |=> op_reject && !op_accept;
    endproperty
    a_blk_erase: assert property (p_blk_erase) // see R7
        else $error("block erase not refused");

    property p_range;
        @(posedge clk) disable iff (sys_rst)
        e_size == 7'h7F |-> range_end == EEPROM_BASE + 24'hFFF;
    endproperty
    a_range: assert property (p_range) // see R9
        else $error("protected range size wrong");

    property p_bad_key;
        @(posedge clk) disable iff (sys_rst)
        ex_miss |=> !ovrd_q ##1 done_q;
    endproperty
    a_bad_key: assert property (p_bad_key) // see R15
        else $error("override kept after bad key");

    property p_hit;
        @(posedge clk) disable iff (sys_rst)
        ex_hit && sel[1] |=> ovrd_q && eprot_q == $past(cmd_q[7]);
    endproperty
    a_hit: assert property (p_hit) // see R14
        else $error("override not applied");

    property p_err_keep;
        @(posedge clk) disable iff (sys_rst)
        ex_err |=> $stable(eprot_q) && $stable(fl_prot_q) && acc_err_q;
    endproperty
    a_err_keep: assert property (p_err_keep) // see R17
        else $error("protection changed on access error");

    property p_done;
        @(posedge clk) disable iff (sys_rst)
        ce && launch |=> !done_q ##1 (done_q || !ce);
    endproperty
    a_done: assert property (p_done) // see R18
        else $error("completion not reported");
endmodule

// *** pkg/nvm_prot_pkg.sv ***
// Constants for the nonvolatile memory protection block.
// Assumes a 32-bit register bus, each register one aligned word.
package nvm_prot_pkg;
    // ----------------------------------------
    // Register indices, byte address is 4x
    // ----------------------------------------
    localparam logic [5:0] IDX_DIVIDER = 6'h00;
    localparam logic [5:0] IDX_STATUS = 6'h01;
    localparam logic [5:0] IDX_PSTAT = 6'h02;
    localparam logic [5:0] IDX_FL_PROT = 6'h03;
    localparam logic [5:0] IDX_EPROT = 6'h04;
    localparam logic [5:0] IDX_IRQ_STATUS = 6'h05;
    localparam logic [5:0] IDX_IRQ_ENABLE = 6'h06;
    localparam logic [5:0] IDX_IRQ_CLEAR = 6'h07;
    localparam logic [5:0] IDX_CMD_FIRST = 6'h0C;
    localparam logic [5:0] IDX_CMD2_LOW = 6'h11;
    localparam logic [5:0] IDX_CMD3_HIGH = 6'h12;
    localparam logic [5:0] IDX_CMD3_LOW = 6'h13;
    localparam logic [5:0] IDX_CMD4_HIGH = 6'h14;
    localparam logic [5:0] IDX_CMD4_LOW = 6'h15;
    localparam logic [5:0] IDX_CMD5_HIGH = 6'h16;
    localparam logic [5:0] IDX_CMD_LAST = 6'h17;
    localparam int CMD_BYTES = 12;
    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int DIV_LOADED_BIT = 7;
    localparam int DIV_LOCK_BIT = 6;
    localparam int EPROT_OPEN_BIT = 7;
    localparam int STATUS_DONE_BIT = 7;
    localparam int STATUS_ERR_BIT = 5;
    localparam int STATUS_VIOL_BIT = 4;
    localparam int PSTAT_OVRD_BIT = 0;
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_VIOL_BIT = 1;
    localparam int IRQ_ERR_BIT = 2;
    // ----------------------------------------
    // Values
    // ----------------------------------------
    localparam logic [7:0] DIV_RESET = 8'h00;
    localparam logic [7:0] EPROT_FULL = 8'h7F;
    localparam logic [7:0] FL_PROT_RESET = 8'hFF;
    localparam logic [7:0] CMD_OVERRIDE = 8'h13;
    localparam logic [15:0] KEY_ERASED = 16'hFFFF;
    localparam logic [23:0] EEPROM_BASE = 24'h100000;
    localparam logic [23:0] CFG_EPROT_ADDR = 24'hFFFE0D;
    localparam int SECTOR_SHIFT = 5;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage

// *** sim/nvm_prot_test.sv ***
// Self-checking bench for the protection block: registers, override
// command, operation checks and interrupt; operations and irq use their own ports, the rest AXI4-Lite.
// Assumes the package constants and a 100 MHz clock.
`timescale 1ns/1ps
module nvm_prot_test;
    import nvm_prot_pkg::*;

    logic clk, sys_rst, ce, special_mode_pin, cfg_double_fault;
    logic [7:0] cfg_eeprom_prot_byte, cfg_flash_prot_byte;
    logic [15:0] cfg_override_key;
    logic op_req, op_block_erase, op_reject, op_accept, irq;
    logic [23:0] op_addr;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    logic [1:0] s_axi_bresp, s_axi_rresp, bresp_seen, rr;
    logic [31:0] rd_val;
    int mismatches, cmp_count;

    nvm_prot dut (.clk, .sys_rst, .ce, .special_mode_pin,
        .cfg_eeprom_prot_byte, .cfg_double_fault, .cfg_flash_prot_byte,
        .cfg_override_key, .op_req, .op_addr, .op_block_erase, .op_reject,
        .op_accept, .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ----------------------------------------
    // Bus and check tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got,
                exp);
        end
    endtask

    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        logic aw_done, w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        @(posedge clk);
        s_axi_awaddr <= {idx, 2'b00};
        s_axi_wdata <= {24'h000000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge clk);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_done = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_done = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        // Response rises only at the edge after both were taken, so wait for it
        while (s_axi_bvalid !== 1'b1) @(posedge clk);
        bresp_seen = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [5:0] idx);
        @(posedge clk);
        s_axi_araddr <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge clk); while (s_axi_rvalid !== 1'b1);
        rd_val = s_axi_rdata;
        rr = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    task automatic rdm(input logic [5:0] idx, input logic [7:0] m,
                       input logic [7:0] e);
        rd(idx);
        chk(rd_val & {24'h000000, m}, {24'h000000, e});
        chk({30'h0, rr}, {30'h0, RESP_OKAY});
    endtask

    // Expected result is {reject, accept}, one cycle after the request
    task automatic op(input logic [23:0] a, input logic blk,
                      input logic [1:0] e);
        @(posedge clk);
        op_req <= 1'b1;
        op_addr <= a;
        op_block_erase <= blk;
        @(posedge clk);
        op_req <= 1'b0;
        @(posedge clk);
        chk({30'h0, op_reject, op_accept}, {30'h0, e});
    endtask

    task automatic ovr(input logic [7:0] code, input logic [1:0] sel,
                       input logic [15:0] key, input logic [7:0] fp,
                       input logic [7:0] ep);
        wr(IDX_CMD_FIRST, code);
        wr(6'h0D, {6'h00, sel});
        wr(6'h0E, key[15:8]);
        wr(6'h0F, key[7:0]);
        wr(IDX_CMD2_LOW, fp);
        wr(IDX_CMD3_LOW, ep);
        wr(IDX_STATUS, 8'h80);
        do rd(IDX_STATUS); while (rd_val[STATUS_DONE_BIT] !== 1'b1);
    endtask

    task automatic rst(input logic flt, input logic spec,
                       input logic [15:0] key);
        @(posedge clk);
        cfg_double_fault <= flt;
        special_mode_pin <= spec;
        cfg_override_key <= key;
        sys_rst <= 1'b1;
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge clk);
    endtask

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        mismatches = 0;
        cmp_count = 0;
        sys_rst = 1'b1;
        ce = 1'b1;
        special_mode_pin = 1'b0;
        cfg_double_fault = 1'b0;
        cfg_eeprom_prot_byte = 8'h05;
        cfg_flash_prot_byte = 8'hF0;
        cfg_override_key = 16'h1234;
        op_req = 1'b0;
        op_addr = 24'h000000;
        op_block_erase = 1'b0;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_wdata = 32'h00000000;
        s_axi_wstrb = 4'hF;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'b000;
        {s_axi_arvalid, s_axi_rready} = 2'b00;
        rst(1'b0, 1'b0, 16'h1234);
        rdm(IDX_EPROT, 8'hFF, 8'h05);
        rdm(IDX_FL_PROT, 8'hFF, 8'hF0);
        rdm(IDX_PSTAT, 8'h01, 8'h00);
        // Size field 5 guards 192 bytes: last protected byte is 0xBF
        op(EEPROM_BASE + 24'h0000BF, 1'b0, 2'b10);
        op(EEPROM_BASE + 24'h0000C0, 1'b0, 2'b01);
        // Enable low: the request must not be judged at all
        ce <= 1'b0;
        op(EEPROM_BASE, 1'b0, 2'b00);
        ce <= 1'b1;
        rdm(IDX_STATUS, 8'h10, 8'h10);
        op(EEPROM_BASE + 24'h000200, 1'b1, 2'b10);
        wr(IDX_DIVIDER, 8'h45);
        chk({30'h0, bresp_seen}, {30'h0, RESP_OKAY});
        wr(IDX_DIVIDER, 8'h0A);
        rdm(IDX_DIVIDER, 8'hFF, 8'hC5);
        wr(IDX_STATUS, 8'h30);
        wr(IDX_IRQ_CLEAR, 8'h07);
        wr(IDX_IRQ_ENABLE, 8'h02);
        chk({31'h0, irq}, 32'h0);
        op(EEPROM_BASE, 1'b0, 2'b10);
        chk({31'h0, irq}, 32'h1);
        rdm(IDX_IRQ_STATUS, 8'h07, 8'h02);
        wr(IDX_IRQ_ENABLE, 8'h00);
        chk({31'h0, irq}, 32'h0);
        wr(IDX_IRQ_ENABLE, 8'h02);
        chk({31'h0, irq}, 32'h1);
        wr(IDX_IRQ_CLEAR, 8'h02);
        chk({31'h0, irq}, 32'h0);
        rdm(IDX_IRQ_CLEAR, 8'hFF, 8'h00);
        wr(IDX_STATUS, 8'h30);
        ovr(CMD_OVERRIDE, 2'b11, 16'h1234, 8'h5A, 8'h80);
        rdm(IDX_FL_PROT, 8'hFF, 8'h5A);
        rdm(IDX_EPROT, 8'hFF, 8'h80);
        rdm(IDX_PSTAT, 8'h01, 8'h01);
        rdm(IDX_STATUS, 8'hB0, 8'h80);
        op(EEPROM_BASE, 1'b0, 2'b01);
        op(EEPROM_BASE, 1'b1, 2'b01);
        ovr(CMD_OVERRIDE, 2'b11, 16'h1235, 8'h11, 8'h11);
        rdm(IDX_FL_PROT, 8'hFF, 8'hF0);
        rdm(IDX_EPROT, 8'hFF, 8'h05);
        rdm(IDX_PSTAT, 8'h01, 8'h00);
        ovr(CMD_OVERRIDE, 2'b10, 16'h1234, 8'h22, 8'h07);
        rdm(IDX_FL_PROT, 8'hFF, 8'hF0);
        rdm(IDX_EPROT, 8'hFF, 8'h07);
        ovr(CMD_OVERRIDE, 2'b01, 16'hFFFF, 8'h33, 8'h33);
        rdm(IDX_FL_PROT, 8'hFF, 8'hF0);
        rdm(IDX_EPROT, 8'hFF, 8'h05);
        rdm(IDX_PSTAT, 8'h01, 8'h00);
        ovr(8'h12, 2'b11, 16'h1234, 8'h44, 8'h44);
        rdm(IDX_STATUS, 8'h20, 8'h20);
        rdm(IDX_FL_PROT, 8'hFF, 8'hF0);
        rdm(IDX_EPROT, 8'hFF, 8'h05);
        rd(6'h20);
        chk({30'h0, rr}, {30'h0, RESP_DECERR});
        chk(rd_val, 32'h00000000);
        wr(6'h20, 8'h55);
        chk({30'h0, bresp_seen}, {30'h0, RESP_DECERR});
        // Special mode, faulty protection byte, erased stored key
        rst(1'b1, 1'b1, KEY_ERASED);
        rdm(IDX_EPROT, 8'hFF, EPROT_FULL);
        wr(IDX_EPROT, 8'h33);
        wr(IDX_EPROT, 8'h02);
        rdm(IDX_EPROT, 8'hFF, 8'h02);
        wr(IDX_DIVIDER, 8'h45);
        wr(IDX_DIVIDER, 8'h0A);
        rdm(IDX_DIVIDER, 8'hFF, 8'h8A);
        ovr(CMD_OVERRIDE, 2'b11, KEY_ERASED, 8'h5A, 8'h80);
        rdm(IDX_PSTAT, 8'h01, 8'h00);
        rdm(IDX_EPROT, 8'hFF, 8'h02);
        complete_run();
    end

    // Whole run needs under a thousand cycles; this is ample margin
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        complete_run();
    end
endmodule
